// ===== src/rcr_pkg.sv
// Constants shared by the clock/calendar core and its advance logic.
package rcr_pkg;
  // Register offsets.
  localparam logic [6:0] OFF_SEC     = 7'h00;
  localparam logic [6:0] OFF_SEC_ALM = 7'h01;
  localparam logic [6:0] OFF_MIN     = 7'h02;
  localparam logic [6:0] OFF_MIN_ALM = 7'h03;
  localparam logic [6:0] OFF_HR      = 7'h04;
  localparam logic [6:0] OFF_HR_ALM  = 7'h05;
  localparam logic [6:0] OFF_WDAY    = 7'h06;
  localparam logic [6:0] OFF_DATE    = 7'h07;
  localparam logic [6:0] OFF_MON     = 7'h08;
  localparam logic [6:0] OFF_YR      = 7'h09;
  localparam logic [6:0] OFF_CTRL_A  = 7'h0A;
  localparam logic [6:0] OFF_CTRL_B  = 7'h0B;
  localparam logic [6:0] OFF_STAT_C  = 7'h0C;
  localparam logic [6:0] OFF_STAT_D  = 7'h0D;
  localparam logic [6:0] OFF_RAM     = 7'h0E;
  localparam int         RAM_WORDS   = 114;
  // Index of each time byte in the time array, with its offset and reset value.
  localparam int IDX_SEC  = 0;
  localparam int IDX_MIN  = 1;
  localparam int IDX_HR   = 2;
  localparam int IDX_WDAY = 3;
  localparam int IDX_DATE = 4;
  localparam int IDX_MON  = 5;
  localparam int IDX_YR   = 6;
  localparam logic [6:0] TIME_OFF [7] = '{7'h00, 7'h02, 7'h04, 7'h06, 7'h07, 7'h08, 7'h09};
  localparam logic [7:0] TIME_RST [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [6:0] ALM_OFF  [3] = '{7'h01, 7'h03, 7'h05};
  // Control register B bits.
  localparam int B_SET = 7;
  localparam int B_PER_IE  = 6;
  localparam int B_ALM_IE  = 5;
  localparam int B_UPD_IE  = 4;
  localparam int B_FMT_BIN = 2;
  localparam int B_H24 = 1;
  localparam int HR_PM_BIT = 7;
  // Divider control patterns that run and reset the clock, and the alarm don't-care code.
  localparam logic [2:0] DV_RUN   = 3'h2;
  localparam logic [1:0] DV_RESET = 2'h3;
  localparam logic [1:0] ALM_DC   = 2'h3;
  // Field limits in BCD and binary.
  localparam logic [7:0] SEC_MAX_BCD  = 8'h59;
  localparam logic [7:0] SEC_MAX_BIN  = 8'h3B;
  localparam logic [7:0] H24_MAX_BCD  = 8'h23;
  localparam logic [7:0] H24_MAX_BIN  = 8'h17;
  localparam logic [7:0] H12_MAX_BCD  = 8'h12;
  localparam logic [7:0] H12_MAX_BIN  = 8'h0C;
  localparam logic [7:0] H11_BCD      = 8'h11;
  localparam logic [7:0] H11_BIN      = 8'h0B;
  localparam logic [7:0] WDAY_MAX     = 8'h07;
  localparam logic [7:0] MON_MAX_BCD  = 8'h12;
  localparam logic [7:0] MON_MAX_BIN  = 8'h0C;
  localparam logic [7:0] YR_MAX_BCD   = 8'h99;
  localparam logic [7:0] YR_MAX_BIN   = 8'h63;
  // Timing.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned POWER_UP_RECOVERY_DELAY_MS = 200;
  localparam int unsigned REC_CYCLES_DEF = POWER_UP_RECOVERY_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned PENDING_LEAD_US = 244;
  localparam int unsigned PENDING_LEAD_TICKS = (PENDING_LEAD_US * OSC_HZ + 999_999) / 1_000_000;
endpackage

// ===== src/rcr_adv_if.sv
// Bundle between the register core and the once-per-second advance logic.
`timescale 1ns/1ps
`default_nettype none
interface rcr_adv_if;
  logic [7:0] cur [7];
  logic [7:0] nxt [7];
  logic       bin_mode;
  logic       h24;
  logic       midnight;
  modport calc (input cur, input bin_mode, input h24, output nxt, output midnight);
  modport core (output cur, output bin_mode, output h24, input nxt, input midnight);
endinterface
`default_nettype wire

// ===== src/rcr_time_advance.sv
// Next-second values of the seven time and calendar bytes.
`timescale 1ns/1ps
`default_nettype none
module rcr_time_advance (
  rcr_adv_if.calc adv
);
  function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] mx,
                                      input logic [7:0] mn, input logic bin);
    if (v == mx)
      step = mn;
    else if (!bin && v[3:0] == 4'h9)
      step = {v[7:4] + 4'h1, 4'h0};
    else
      step = v + 8'h01;
  endfunction

  logic       bin;
  logic [7:0] sec_max;
  logic [7:0] hr;
  logic [7:0] hv;
  logic [7:0] h12_max;
  logic [7:0] h11;
  logic [7:0] h24_max;
  logic [7:0] hr_nxt;
  logic       hr_wrap;
  logic [3:0] mnum;
  logic       leap;
  logic [7:0] days;
  logic [7:0] dmax;
  logic [7:0] mon_max;
  logic       c_sec;
  logic       c_min;
  logic       c_date;
  logic       c_mon;

  always_comb
  begin
    bin     = adv.bin_mode;
    sec_max = bin ? rcr_pkg::SEC_MAX_BIN : rcr_pkg::SEC_MAX_BCD;
    h12_max = bin ? rcr_pkg::H12_MAX_BIN : rcr_pkg::H12_MAX_BCD;
    h11     = bin ? rcr_pkg::H11_BIN : rcr_pkg::H11_BCD;
    h24_max = bin ? rcr_pkg::H24_MAX_BIN : rcr_pkg::H24_MAX_BCD;
    mon_max = bin ? rcr_pkg::MON_MAX_BIN : rcr_pkg::MON_MAX_BCD;
    hr      = adv.cur[rcr_pkg::IDX_HR];
    hv      = {1'b0, hr[6:0]};
    if (adv.h24)
    begin
      hr_nxt  = step(hr, h24_max, 8'h00, bin);
      hr_wrap = (hr == h24_max);
    end
    else
    begin
      // The PM flag flips going from 11 to 12; 11 PM to 12 AM is midnight.
      hr_nxt = (hv == h12_max) ? 8'h01 : step(hv, h12_max, 8'h01, bin);
      hr_nxt[rcr_pkg::HR_PM_BIT] = hr[rcr_pkg::HR_PM_BIT] ^ (hv == h11);
      hr_wrap = hr[rcr_pkg::HR_PM_BIT] && (hv == h11);
    end
    // Month length with leap years taken as every year divisible by four.
    mnum = adv.cur[rcr_pkg::IDX_MON][3:0];
    if (!bin && adv.cur[rcr_pkg::IDX_MON][4])
      mnum = adv.cur[rcr_pkg::IDX_MON][3:0] + 4'hA;
    if (bin)
      leap = (adv.cur[rcr_pkg::IDX_YR][1:0] == 2'h0);
    else if (adv.cur[rcr_pkg::IDX_YR][4])
      leap = (adv.cur[rcr_pkg::IDX_YR][3:0] == 4'h2) || (adv.cur[rcr_pkg::IDX_YR][3:0] == 4'h6);
    else
      leap = (adv.cur[rcr_pkg::IDX_YR][3:0] == 4'h0) || (adv.cur[rcr_pkg::IDX_YR][3:0] == 4'h4)
          || (adv.cur[rcr_pkg::IDX_YR][3:0] == 4'h8);
    unique case (mnum)
      4'h2:                      days = leap ? 8'h1D : 8'h1C;
      4'h4, 4'h6, 4'h9, 4'hB:    days = 8'h1E;
      default:                   days = 8'h1F;
    endcase
    // In BCD, 28 and 29 are the binary value plus 12, while 30 and 31 are plus 18.
    dmax   = bin ? days : days + ((days >= 8'h1E) ? 8'h12 : 8'h0C);
    c_sec  = (adv.cur[rcr_pkg::IDX_SEC] == sec_max);
    c_min  = c_sec && (adv.cur[rcr_pkg::IDX_MIN] == sec_max);
    adv.midnight = c_min && hr_wrap;
    c_date = adv.midnight && (adv.cur[rcr_pkg::IDX_DATE] == dmax);
    c_mon  = c_date && (adv.cur[rcr_pkg::IDX_MON] == mon_max);
    // Each byte steps in the selected encoding, carrying upward.
    adv.nxt[rcr_pkg::IDX_SEC] = step(adv.cur[rcr_pkg::IDX_SEC], sec_max, 8'h00, bin);
    adv.nxt[rcr_pkg::IDX_MIN] = c_sec ? step(adv.cur[rcr_pkg::IDX_MIN], sec_max, 8'h00, bin)
                                      : adv.cur[rcr_pkg::IDX_MIN];
    adv.nxt[rcr_pkg::IDX_HR]  = c_min ? hr_nxt : hr;
    // Day of week runs 1 to 7 and steps at midnight.
    adv.nxt[rcr_pkg::IDX_WDAY] = adv.midnight
        ? step(adv.cur[rcr_pkg::IDX_WDAY], rcr_pkg::WDAY_MAX, 8'h01, bin)
        : adv.cur[rcr_pkg::IDX_WDAY];
    adv.nxt[rcr_pkg::IDX_DATE] = adv.midnight
        ? step(adv.cur[rcr_pkg::IDX_DATE], dmax, 8'h01, bin) : adv.cur[rcr_pkg::IDX_DATE];
    adv.nxt[rcr_pkg::IDX_MON] = c_date
        ? step(adv.cur[rcr_pkg::IDX_MON], mon_max, 8'h01, bin) : adv.cur[rcr_pkg::IDX_MON];
    adv.nxt[rcr_pkg::IDX_YR] = c_mon
        ? step(adv.cur[rcr_pkg::IDX_YR], bin ? rcr_pkg::YR_MAX_BIN : rcr_pkg::YR_MAX_BCD,
               8'h00, bin)
        : adv.cur[rcr_pkg::IDX_YR];
  end
endmodule
`default_nettype wire

// ===== src/rcr_core.sv
// Clock/calendar register core with alarm, divider chain and power-up access gate.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rcr_core #(
  parameter int unsigned REC_CYCLES = rcr_pkg::REC_CYCLES_DEF,
  parameter int unsigned TICKS      = rcr_pkg::OSC_HZ
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       osc_32k_i,
  input  wire logic       vcc_ok_i,
  input  wire logic       backup_supply_ok_i,
  output logic      [7:0] rdata_o,
  output logic            irq_n_o,
  output logic            access_ok_o
);
  localparam int DW = $clog2(TICKS);

  logic [7:0] time_reg  [7];
  logic [7:0] alarm_reg [3];
  logic [7:0] ram       [rcr_pkg::RAM_WORDS];
  logic [6:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic       alarm_match_flag;
  logic       update_end_flag;
  logic       update_pending_flag;
  logic [DW-1:0] div_cnt;
  logic [31:0] rec_cnt;
  logic       rec_busy;
  logic       access_reg;
  logic       cmp_pend;
  logic       osc_s1;
  logic       osc_s2;
  logic       osc_s3;
  logic       vcc_s1;
  logic       vcc_s2;
  logic       vcc_s3;
  logic       bak_s1;
  logic       backup_valid_flag;
  logic [7:0] rdata_reg;
  logic       irq_n_reg;

  logic       wr_ok;
  logic       rd_ok;
  logic       osc_edge;
  logic       run;
  logic       osc_on;
  logic       upd;
  logic       vcc_rise;
  logic       osc_set;
  logic       dv_start;
  logic       rd_stat_c;
  logic       alarm_hit;
  logic       any_irq_flag;
  logic [6:0] ram_idx;
  logic [7:0] rd_val;

  rcr_adv_if adv ();

  rcr_time_advance u_adv (
    .adv (adv)
  );

  assign adv.bin_mode = ctrl_b_reg[rcr_pkg::B_FMT_BIN];
  assign adv.h24      = ctrl_b_reg[rcr_pkg::B_H24];

  // Host access is dropped while the main supply is low; counting never is.
  assign wr_ok     = wr_i && access_reg;
  assign rd_ok     = rd_i && access_reg;
  assign rd_stat_c = rd_ok && (addr_i == rcr_pkg::OFF_STAT_C);
  assign osc_edge  = osc_s2 && !osc_s3;
  assign run       = (ctrl_a_reg[6:4] == rcr_pkg::DV_RUN);
  assign osc_on    = run || (ctrl_a_reg[6:5] == rcr_pkg::DV_RESET);
  assign vcc_rise  = vcc_s2 && !vcc_s3;
  assign osc_set   = vcc_rise && !osc_on;
  assign dv_start  = (wr_ok && (addr_i == rcr_pkg::OFF_CTRL_A)
                      && (wdata_i[6:4] == rcr_pkg::DV_RUN) && !run) || osc_set;
  // One update a second, held off while the inhibit bit is set.
  assign upd = run && osc_edge && (div_cnt == DW'(TICKS - 1))
               && !ctrl_b_reg[rcr_pkg::B_SET];
  assign ram_idx = addr_i - rcr_pkg::OFF_RAM;

  // Pins from outside the clock domain pass two flip-flops before use.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      vcc_s1 <= 1'b0;
      vcc_s2 <= 1'b0;
      vcc_s3 <= 1'b0;
      bak_s1 <= 1'b0;
      backup_valid_flag <= 1'b0;
    end
    else
    begin
      osc_s1 <= osc_32k_i;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      vcc_s1 <= vcc_ok_i;
      vcc_s2 <= vcc_s1;
      vcc_s3 <= vcc_s2;
      bak_s1 <= backup_supply_ok_i;
      backup_valid_flag <= bak_s1;
    end
  end

  // Divider chain; a start from the reset pattern puts the first update a full second away, any other start half a second.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      div_cnt <= '0;
    else if (ctrl_a_reg[6:5] == rcr_pkg::DV_RESET)
      div_cnt <= '0;
    else if (dv_start)
      div_cnt <= DW'(TICKS / 2);
    else if (run && osc_edge)
      div_cnt <= (div_cnt == DW'(TICKS - 1)) ? '0 : div_cnt + 1'b1;
  end

  // The pending flag warns software shortly before an update lands.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      update_pending_flag <= 1'b0;
    else
      update_pending_flag <= run && !ctrl_b_reg[rcr_pkg::B_SET]
                             && (div_cnt >= DW'(TICKS - rcr_pkg::PENDING_LEAD_TICKS));
  end

  // Power-up gate: wait the recovery delay only if the clock was already running.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      access_reg <= 1'b0;
      rec_busy   <= 1'b0;
      rec_cnt    <= '0;
    end
    else if (!vcc_s2)
    begin
      access_reg <= 1'b0;
      rec_busy   <= 1'b0;
      rec_cnt    <= '0;
    end
    else if (vcc_rise)
    begin
      access_reg <= !run;
      rec_busy   <= run;
      rec_cnt    <= '0;
    end
    else if (rec_busy)
    begin
      if (rec_cnt == REC_CYCLES - 1)
      begin
        access_reg <= 1'b1;
        rec_busy   <= 1'b0;
      end
      else
        rec_cnt <= rec_cnt + 32'h1;
    end
  end

  // Time bytes: a host write to a byte wins over the update of that byte.
  for (genvar g = 0; g < 7; g++)
  begin : g_time
    assign adv.cur[g] = time_reg[g];
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
        time_reg[g] <= rcr_pkg::TIME_RST[g];
      else if (wr_ok && (addr_i == rcr_pkg::TIME_OFF[g]))
        time_reg[g] <= (g == rcr_pkg::IDX_SEC) ? {1'b0, wdata_i[6:0]} : wdata_i;
      else if (upd)
        time_reg[g] <= adv.nxt[g];
    end
  end

  // Alarm bytes and RAM are written only by the host and never reset.
  for (genvar g = 0; g < 3; g++)
  begin : g_alarm
    always_ff @(posedge clk_i)
    begin
      if (wr_ok && (addr_i == rcr_pkg::ALM_OFF[g]))
        alarm_reg[g] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (wr_ok && (addr_i >= rcr_pkg::OFF_RAM))
      ram[ram_idx] <= wdata_i;
  end

  // Control A: the top bit is status only; power-up may switch the oscillator on.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      ctrl_a_reg <= 7'h00;
    else if (osc_set)
      ctrl_a_reg[6:4] <= rcr_pkg::DV_RUN;
    else if (wr_ok && (addr_i == rcr_pkg::OFF_CTRL_A))
      ctrl_a_reg <= wdata_i[6:0];
  end

  // Control B: raising the inhibit bit also clears the update-end enable.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      ctrl_b_reg <= 8'h00;
    else if (wr_ok && (addr_i == rcr_pkg::OFF_CTRL_B))
    begin
      ctrl_b_reg <= wdata_i;
      if (wdata_i[rcr_pkg::B_SET] && !ctrl_b_reg[rcr_pkg::B_SET])
        ctrl_b_reg[rcr_pkg::B_UPD_IE] <= 1'b0;
    end
  end

  // Alarm compare runs one cycle after the update, on the new time.
  always_comb
  begin
    alarm_hit = 1'b1;
    for (int i = 0; i < 3; i++)
      if (alarm_reg[i][7:6] != rcr_pkg::ALM_DC && alarm_reg[i] != time_reg[i])
        alarm_hit = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cmp_pend <= 1'b0;
    else
      cmp_pend <= upd;
  end

  // Flags clear on a read of status C, but a new event in that cycle wins.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      alarm_match_flag <= 1'b0;
      update_end_flag  <= 1'b0;
    end
    else
    begin
      alarm_match_flag <= (cmp_pend && alarm_hit) || (alarm_match_flag && !rd_stat_c);
      update_end_flag  <= cmp_pend || (update_end_flag && !rd_stat_c);
    end
  end

  assign any_irq_flag = (alarm_match_flag && ctrl_b_reg[rcr_pkg::B_ALM_IE])
                     || (update_end_flag && ctrl_b_reg[rcr_pkg::B_UPD_IE]);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      irq_n_reg <= 1'b1;
    else
      irq_n_reg <= !any_irq_flag;
  end

  // Read mux; status C and D are composed here and cannot be written.
  always_comb
  begin
    rd_val = 8'h00;
    unique case (addr_i)
      rcr_pkg::OFF_SEC:     rd_val = time_reg[rcr_pkg::IDX_SEC];
      rcr_pkg::OFF_SEC_ALM: rd_val = alarm_reg[0];
      rcr_pkg::OFF_MIN:     rd_val = time_reg[rcr_pkg::IDX_MIN];
      rcr_pkg::OFF_MIN_ALM: rd_val = alarm_reg[1];
      rcr_pkg::OFF_HR:      rd_val = time_reg[rcr_pkg::IDX_HR];
      rcr_pkg::OFF_HR_ALM:  rd_val = alarm_reg[2];
      rcr_pkg::OFF_WDAY:    rd_val = time_reg[rcr_pkg::IDX_WDAY];
      rcr_pkg::OFF_DATE:    rd_val = time_reg[rcr_pkg::IDX_DATE];
      rcr_pkg::OFF_MON:     rd_val = time_reg[rcr_pkg::IDX_MON];
      rcr_pkg::OFF_YR:      rd_val = time_reg[rcr_pkg::IDX_YR];
      rcr_pkg::OFF_CTRL_A:  rd_val = {update_pending_flag, ctrl_a_reg};
      rcr_pkg::OFF_CTRL_B:  rd_val = ctrl_b_reg;
      rcr_pkg::OFF_STAT_C:  rd_val = {any_irq_flag, 1'b0, alarm_match_flag,
                                      update_end_flag, 4'h0};
      rcr_pkg::OFF_STAT_D:  rd_val = {backup_valid_flag, 7'h00};
      default:              rd_val = ram[ram_idx];
    endcase
  end

  // Read data stand for one cycle; a refused read returns zero.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rd_ok ? rd_val : 8'h00;
  end

  assign rdata_o     = rdata_reg;
  assign irq_n_o     = irq_n_reg;
  assign access_ok_o = access_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_refuse;
    rd_i && !access_reg |=> rdata_o == 8'h00;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused read returned data");

  property p_osc_set;
    vcc_rise && !osc_on |=> access_reg && ctrl_a_reg[6:4] == rcr_pkg::DV_RUN;
  endproperty
  a_osc_set: assert property (p_osc_set) else $error("oscillator not enabled at power-up");

  property p_wday_wrap;
    upd && adv.midnight && time_reg[rcr_pkg::IDX_WDAY] == 8'h07 && !wr_ok
      |=> time_reg[rcr_pkg::IDX_WDAY] == 8'h01;
  endproperty
  a_wday_wrap: assert property (p_wday_wrap) else $error("weekday did not wrap to 1");

  property p_april_end;
    upd && adv.midnight && !adv.bin_mode && time_reg[rcr_pkg::IDX_MON] == 8'h04
      && time_reg[rcr_pkg::IDX_DATE] == 8'h30 && !wr_ok
      |=> time_reg[rcr_pkg::IDX_DATE] == 8'h01 && time_reg[rcr_pkg::IDX_MON] == 8'h05;
  endproperty
  a_april_end: assert property (p_april_end) else $error("short month not rolled");

  property p_sec_bcd;
    upd && !adv.bin_mode && time_reg[rcr_pkg::IDX_SEC] == 8'h59 && !wr_ok
      |=> time_reg[rcr_pkg::IDX_SEC] == 8'h00 && $changed(time_reg[rcr_pkg::IDX_MIN]);
  endproperty
  a_sec_bcd: assert property (p_sec_bcd) else $error("bcd seconds carry wrong");

  property p_sec_bin;
    upd && adv.bin_mode && time_reg[rcr_pkg::IDX_SEC] == 8'h3B && !wr_ok
      |=> time_reg[rcr_pkg::IDX_SEC] == 8'h00;
  endproperty
  a_sec_bin: assert property (p_sec_bin) else $error("binary seconds wrap wrong");

  property p_pm;
    upd && !adv.h24 && !adv.bin_mode && time_reg[rcr_pkg::IDX_HR] == 8'h11
      && time_reg[rcr_pkg::IDX_MIN] == 8'h59 && time_reg[rcr_pkg::IDX_SEC] == 8'h59 && !wr_ok
      |=> time_reg[rcr_pkg::IDX_HR] == 8'h92;
  endproperty
  a_pm: assert property (p_pm) else $error("pm flag not set at noon");

  property p_sec_ro;
    wr_ok && addr_i == rcr_pkg::OFF_SEC |=> !time_reg[rcr_pkg::IDX_SEC][7];
  endproperty
  a_sec_ro: assert property (p_sec_ro) else $error("seconds top bit written");

  property p_hold;
    !run && !wr_ok |=> $stable(time_reg[rcr_pkg::IDX_SEC]);
  endproperty
  a_hold: assert property (p_hold) else $error("time moved with divider stopped");

  property p_alarm_all_dc;
    upd && alarm_reg[0][7:6] == 2'h3 && alarm_reg[1][7:6] == 2'h3 && alarm_reg[2][7:6] == 2'h3
      && !wr_ok |=> ##1 alarm_match_flag;
  endproperty
  a_alarm_all_dc: assert property (p_alarm_all_dc) else $error("don't-care alarm missed");

  property p_irq_gate;
    !ctrl_b_reg[rcr_pkg::B_ALM_IE] && !ctrl_b_reg[rcr_pkg::B_UPD_IE] |=> irq_n_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt driven while disabled");

  c_alarm: cover property (cmp_pend && alarm_hit);
  c_midnight: cover property (upd && adv.midnight);
  c_recovered: cover property (rec_busy ##1 !rec_busy && access_reg);
  c_stat_clear: cover property (rd_stat_c && alarm_match_flag);
endmodule
`default_nettype wire

// ===== sim/rcr_osc_model.sv
// Stand-in for the 32.768 kHz oscillator pin, scaled to the short divider.
`timescale 1ns/1ps
`default_nettype none
module rcr_osc_model #(
  parameter int HALF = 4
) (
  input  wire logic clk_i,
  output logic      osc_o
);
  int   cnt   = 0;
  logic osc_q = 1'b0;
  assign osc_o = osc_q;
  always @(posedge clk_i)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      osc_q <= ~osc_q;
  end
endmodule
`default_nettype wire

// ===== sim/rtc_calendar_alarm_regs_tb.sv
// Register-level testbench of the clock/calendar core.
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_alarm_regs_tb;
  logic       clk_i;
  logic       rst_n_i;
  logic       wr_i;
  logic       rd_i;
  logic       vcc_ok_i;
  logic       osc;
  logic [6:0] addr_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic       irq_n_o;
  logic       access_ok_o;
  int         mismatches = 0;
  int         checks = 0;

  rcr_osc_model osc_u (.clk_i(clk_i), .osc_o(osc));
  // A short divider keeps one second at 128 clock cycles.
  rcr_core #(.REC_CYCLES(20), .TICKS(16)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .osc_32k_i(osc),
    .vcc_ok_i(vcc_ok_i), .backup_supply_ok_i(1'b1), .rdata_o(rdata_o),
    .irq_n_o(irq_n_o), .access_ok_o(access_ok_o));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e,
                    input string n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(n, e, rdata_o & m);
  endtask

  task automatic set_time(input logic [7:0] t [7]);
    for (int i = 0; i < 7; i++)
      wr(rcr_pkg::TIME_OFF[i], t[i]);
  endtask

  task automatic chk_time(input logic [7:0] t [7]);
    for (int i = 0; i < 7; i++)
      rd(rcr_pkg::TIME_OFF[i], 8'hFF, t[i], "time byte");
  endtask

  task automatic wait_irq;
    for (int i = 0; i < 400 && irq_n_o !== 1'b0; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk("irq_n", 8'h00, {7'h00, irq_n_o});
  endtask

  initial
  begin
    #60000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    rst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; vcc_ok_i = 1'b0;
    addr_i = 7'h00; wdata_i = 8'h00;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    vcc_ok_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1 chk("access", 8'h01, {7'h00, access_ok_o});
    rd(7'h0A, 8'h70, 8'h20, "ctrl_a");
    wr(7'h0B, 8'h82);
    set_time('{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h04});
    for (int i = 0; i < 3; i++)
      wr(rcr_pkg::ALM_OFF[i], 8'hC0);
    wr(7'h0B, 8'h22);
    wait_irq();
    chk_time('{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h04});
    rd(7'h0C, 8'hFF, 8'hB0, "stat_c");
    $display("test bcd rollover done");
    wr(7'h0B, 8'h86);
    set_time('{8'h3B, 8'h3B, 8'h17, 8'h03, 8'h1C, 8'h02, 8'h01});
    rd(7'h0C, 8'hFF, 8'h00, "stat_c clear");
    wr(7'h0B, 8'h26);
    wait_irq();
    chk_time('{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h03, 8'h01});
    $display("test binary rollover done");
    wr(7'h0B, 8'h80);
    set_time('{8'h59, 8'h59, 8'h91, 8'h01, 8'h30, 8'h04, 8'h99});
    rd(7'h0C, 8'hFF, 8'h30, "stat_c masked");
    wr(7'h0B, 8'h20);
    wait_irq();
    chk_time('{8'h00, 8'h00, 8'h12, 8'h02, 8'h01, 8'h05, 8'h99});
    $display("test 12-hour month end done");
    wr(7'h0B, 8'h80);
    wr(7'h00, 8'hA5);
    wr(7'h0C, 8'hFF);
    wr(7'h0D, 8'h7F);
    wr(7'h0A, 8'hA0);
    rd(7'h00, 8'hFF, 8'h25, "sec");
    rd(7'h0D, 8'hFF, 8'h80, "stat_d");
    rd(7'h0A, 8'hFF, 8'h20, "ctrl_a");
    wr(7'h0E, 8'h5A);
    wr(7'h7F, 8'hA5);
    rd(7'h0E, 8'hFF, 8'h5A, "ram low");
    rd(7'h7F, 8'hFF, 8'hA5, "ram high");
    $display("test map done");
    vcc_ok_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    vcc_ok_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    #1 chk("access", 8'h00, {7'h00, access_ok_o});
    wr(7'h0E, 8'h11);
    rd(7'h0E, 8'hFF, 8'h00, "refused read");
    for (int i = 0; i < 40 && access_ok_o !== 1'b1; i++)
      @(posedge clk_i);
    rd(7'h0E, 8'hFF, 8'h5A, "ram kept");
    $display("test power-up gate done");
    end_of_test();
  end
endmodule
`default_nettype wire
